/* rtl/wake_frame_mask_crc_regs.sv */
`timescale 1ns/100ps
`default_nettype none
module wake_frame_mask_crc_regs (
    input  wire logic        clk_i,                  // Core clock, 50 MHz
    input  wire logic        rst_i,                  // Synchronous reset, high
    input  wire logic [11:0] adr_i,                  // Wishbone byte address
    input  wire logic [31:0] dat_i,                  // Wishbone write data
    input  wire logic [3:0]  sel_i,                  // Wishbone byte selects
    input  wire logic        we_i,                   // Wishbone write
    input  wire logic        cyc_i,                  // Wishbone cycle
    input  wire logic        stb_i,                  // Wishbone strobe
    output logic [31:0]      dat_o,                  // Wishbone read data
    output logic             ack_o,                  // Wishbone acknowledge
    input  wire logic        rx_valid_i,             // Received byte strobe
    input  wire logic [7:0]  rx_data_i,              // Received byte
    input  wire logic        rx_last_i,              // Last byte of frame
    input  wire logic [31:0] pattern0_expected_crc_i,// Slot 0 CRC from neighbour bank
    input  wire logic [63:0] pattern2_mask_i,        // Slot 2 masks from neighbour bank
    output logic [2:0]       wake_hit_o,             // Per-slot match pulse
    output logic             irq_o                   // Level interrupt
);
    ////////////////////////////////////////////////////////////////////////////////
    // Storage
    // Flops only, addressed by word
    logic [15:0] p0_mask_q [4];        // Slot 0 mask words
    logic [15:0] p1_mask_q [4];        // Slot 1 mask words
    logic [15:0] p1_crc_lo_q;          // Slot 1 CRC bits 15-0
    logic [15:0] p1_crc_hi_q;          // Slot 1 CRC bits 31-16
    logic [15:0] p2_crc_lo_q;          // Slot 2 CRC bits 15-0
    logic [15:0] p2_crc_hi_q;          // Slot 2 CRC bits 31-16
    logic [2:0]  detect_en_q;          // Per-slot detect enable
    logic [2:0]  evt_status_q;         // Sticky match flags
    logic [2:0]  evt_enable_q;         // Interrupt enables
    logic        ack_q;                // Bus acknowledge
    logic [31:0] rdata_q;              // Registered read data
    logic [31:0] rdata_d;              // Read mux
    logic [6:0]  byte_cnt_q;           // Bytes seen in frame, saturating
    logic [9:0]  idx;                  // Register index from address
    logic        wr_take;              // Write commits this edge
    logic        in_window;            // Byte falls in the first 64
    logic        frame_end;            // Last byte strobe
    logic [63:0] mask_vec  [3];        // Full mask per slot
    logic [31:0] crc_vec   [3];        // Expected CRC per slot
    logic [2:0]  byte_sel;             // Per-slot byte select
    logic [2:0]  hit;                  // Per-slot match pulse

    // Merge a 16-bit register with the low two byte lanes
    // Upper lanes are ignored
    function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0]  be);
        logic [15:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = wd[7:0];
        end
        if (be[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Wishbone slave
    assign idx     = adr_i[11:2];
    // Write lands on the edge where the master sees ack
    // so a held request writes once
    assign wr_take = cyc_i && stb_i && we_i && ack_q;

    // One-cycle ack, dropped the cycle after; every address answers
    // Fixed latency keeps the master simple
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= cyc_i && stb_i && !ack_q;
        end
    end

    // Reads have no side effects
    // Read mux; unmapped and write-only read as zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        unique case (idx)
            wake_regs_pkg::IDX_P0_MASK0:   rdata_d[15:0] = p0_mask_q[0];
            wake_regs_pkg::IDX_P0_MASK1:   rdata_d[15:0] = p0_mask_q[1];
            wake_regs_pkg::IDX_P0_MASK2:   rdata_d[15:0] = p0_mask_q[2];
            wake_regs_pkg::IDX_P0_MASK3:   rdata_d[15:0] = p0_mask_q[3];
            wake_regs_pkg::IDX_DETECT_EN:  rdata_d[2:0]  = detect_en_q;
            wake_regs_pkg::IDX_P1_CRC_LO:  rdata_d[15:0] = p1_crc_lo_q;
            wake_regs_pkg::IDX_P1_CRC_HI:  rdata_d[15:0] = p1_crc_hi_q;
            wake_regs_pkg::IDX_P1_MASK0:   rdata_d[15:0] = p1_mask_q[0];
            wake_regs_pkg::IDX_P1_MASK1:   rdata_d[15:0] = p1_mask_q[1];
            wake_regs_pkg::IDX_P1_MASK2:   rdata_d[15:0] = p1_mask_q[2];
            wake_regs_pkg::IDX_P1_MASK3:   rdata_d[15:0] = p1_mask_q[3];
            wake_regs_pkg::IDX_EVT_STATUS: rdata_d[2:0]  = evt_status_q;
            wake_regs_pkg::IDX_P2_CRC_LO:  rdata_d[15:0] = p2_crc_lo_q;
            wake_regs_pkg::IDX_P2_CRC_HI:  rdata_d[15:0] = p2_crc_hi_q;
            wake_regs_pkg::IDX_EVT_ENABLE: rdata_d[2:0]  = evt_enable_q;
            default:                       rdata_d = 32'h0000_0000;
        endcase
    end

    // Read data captured with the ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (cyc_i && stb_i && !ack_q) begin
            rdata_q <= rdata_d;
        end
    end

    assign ack_o = ack_q;
    assign dat_o = rdata_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Mask registers
    // Lanes merge per byte select
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 4; i++) begin
                p0_mask_q[i] <= wake_regs_pkg::RESET_WORD;
                p1_mask_q[i] <= wake_regs_pkg::RESET_WORD;
            end
        end else if (wr_take) begin
            unique case (idx)
                wake_regs_pkg::IDX_P0_MASK0: p0_mask_q[0] <= lane_merge(p0_mask_q[0], dat_i, sel_i);
                wake_regs_pkg::IDX_P0_MASK1: p0_mask_q[1] <= lane_merge(p0_mask_q[1], dat_i, sel_i);
                wake_regs_pkg::IDX_P0_MASK2: p0_mask_q[2] <= lane_merge(p0_mask_q[2], dat_i, sel_i);
                wake_regs_pkg::IDX_P0_MASK3: p0_mask_q[3] <= lane_merge(p0_mask_q[3], dat_i, sel_i);
                wake_regs_pkg::IDX_P1_MASK0: p1_mask_q[0] <= lane_merge(p1_mask_q[0], dat_i, sel_i);
                wake_regs_pkg::IDX_P1_MASK1: p1_mask_q[1] <= lane_merge(p1_mask_q[1], dat_i, sel_i);
                wake_regs_pkg::IDX_P1_MASK2: p1_mask_q[2] <= lane_merge(p1_mask_q[2], dat_i, sel_i);
                wake_regs_pkg::IDX_P1_MASK3: p1_mask_q[3] <= lane_merge(p1_mask_q[3], dat_i, sel_i);
                default: ;  // Other registers
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Expected CRC registers
    // Halves land apart; disable slot to update
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            p1_crc_lo_q <= wake_regs_pkg::RESET_WORD;
            p1_crc_hi_q <= wake_regs_pkg::RESET_WORD;
            p2_crc_lo_q <= wake_regs_pkg::RESET_WORD;
            p2_crc_hi_q <= wake_regs_pkg::RESET_WORD;
        end else if (wr_take) begin
            unique case (idx)
                wake_regs_pkg::IDX_P1_CRC_LO: p1_crc_lo_q <= lane_merge(p1_crc_lo_q, dat_i, sel_i);
                wake_regs_pkg::IDX_P1_CRC_HI: p1_crc_hi_q <= lane_merge(p1_crc_hi_q, dat_i, sel_i);
                wake_regs_pkg::IDX_P2_CRC_LO: p2_crc_lo_q <= lane_merge(p2_crc_lo_q, dat_i, sel_i);
                wake_regs_pkg::IDX_P2_CRC_HI: p2_crc_hi_q <= lane_merge(p2_crc_hi_q, dat_i, sel_i);
                default: ;  // Other registers
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Enables: detect and interrupt
    // Flag bits live in lane 0 only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            detect_en_q  <= wake_regs_pkg::RESET_FLAGS;
            evt_enable_q <= wake_regs_pkg::RESET_FLAGS;
        end else if (wr_take && sel_i[0]) begin
            if (idx == wake_regs_pkg::IDX_DETECT_EN) begin
                detect_en_q <= dat_i[2:0];
            end
            if (idx == wake_regs_pkg::IDX_EVT_ENABLE) begin
                evt_enable_q <= dat_i[2:0];
            end
        end
    end

    // Sticky flags; a match in the clear cycle survives
    // Set wins so no match is lost
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_status_q <= wake_regs_pkg::RESET_FLAGS;
        end else if (wr_take && sel_i[0] && idx == wake_regs_pkg::IDX_EVT_CLEAR) begin
            evt_status_q <= (evt_status_q & ~dat_i[2:0]) | hit;
        end else begin
            evt_status_q <= evt_status_q | hit;
        end
    end

    assign irq_o      = |(evt_status_q & evt_enable_q);
    assign wake_hit_o = hit;

    ////////////////////////////////////////////////////////////////////////////////
    // Receive byte position
    // Count is zero based: 0 is byte 1
    assign frame_end = rx_valid_i && rx_last_i;
    assign in_window = byte_cnt_q < wake_regs_pkg::WINDOW_BYTES;

    // Counter saturates at 64 so long frames never wrap into the mask
    // Only the last byte restarts it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            byte_cnt_q <= wake_regs_pkg::COUNT_RESET;
        end else if (rx_valid_i) begin
            if (rx_last_i) begin
                byte_cnt_q <= wake_regs_pkg::COUNT_RESET;
            end else if (in_window) begin
                byte_cnt_q <= byte_cnt_q + 7'h01;
            end
        end
    end

    // Mask word n bit b selects byte 16n+b+1
    // Slot 0 CRC, slot 2 masks: neighbour bank
    assign mask_vec[0] = {p0_mask_q[3], p0_mask_q[2], p0_mask_q[1], p0_mask_q[0]};
    assign mask_vec[1] = {p1_mask_q[3], p1_mask_q[2], p1_mask_q[1], p1_mask_q[0]};
    assign mask_vec[2] = pattern2_mask_i;
    assign crc_vec[0]  = pattern0_expected_crc_i;
    assign crc_vec[1]  = {p1_crc_hi_q, p1_crc_lo_q};
    assign crc_vec[2]  = {p2_crc_hi_q, p2_crc_lo_q};

    ////////////////////////////////////////////////////////////////////////////////
    // One matcher per slot
    // Slots share the bytes, not the state
    for (genvar s = 0; s < wake_regs_pkg::NUM_PATTERNS; s++) begin : g_slot
        // Bytes 17-64 index words 1-3 the same way
        assign byte_sel[s] = in_window && mask_vec[s][byte_cnt_q[5:0]];
        wake_pattern_matcher u_match (
            .clk_i          (clk_i),
            .rst_i          (rst_i),
            .enable_i       (detect_en_q[s]),
            .byte_valid_i   (rx_valid_i),
            .byte_data_i    (rx_data_i),
            .byte_select_i  (byte_sel[s]),
            .frame_end_i    (frame_end),
            .expected_crc_i (crc_vec[s]),
            .hit_o          (hit[s])
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    // All checks share the core clock
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_ack_given;
        cyc_i && stb_i && !ack_o ##1 ack_o;
    endsequence

    // Ack is a single pulse
    chk_ack_single_pulse: assert property (s_ack_given |=> !ack_o)
        else $error("Ack held longer than one cycle");

    // Both lanes store the word
    chk_mask_word0_write: assert property (
        wr_take && idx == wake_regs_pkg::IDX_P0_MASK0 && sel_i[1:0] == 2'h3
        |=> p0_mask_q[0] == $past(dat_i[15:0]))
        else $error("Slot 0 first mask word not stored");

    // Low half of slot 1 CRC
    chk_crc_low_write: assert property (
        wr_take && idx == wake_regs_pkg::IDX_P1_CRC_LO && sel_i[1:0] == 2'h3
        |=> crc_vec[1][15:0] == $past(dat_i[15:0]))
        else $error("Low CRC half wrong");

    // High half of slot 2 CRC
    chk_crc_high_write: assert property (
        wr_take && idx == wake_regs_pkg::IDX_P2_CRC_HI && sel_i[1:0] == 2'h3
        |=> crc_vec[2][31:16] == $past(dat_i[15:0]))
        else $error("High CRC half wrong");

    // Nothing past byte 64
    chk_window_limit: assert property (
        rx_valid_i && byte_cnt_q >= 7'h40 |-> byte_sel == 3'h0)
        else $error("Byte past 64 selected");

    // Byte 17 opens word 1
    chk_byte17_select: assert property (
        rx_valid_i && byte_cnt_q == 7'h10 |-> byte_sel[1] == p1_mask_q[1][0])
        else $error("Byte 17 not mapped to second word bit 0");

    // Slot 0 never matches while disabled
    chk_disabled_silent: assert property (
        wake_hit_o[0] |-> $past(detect_en_q[0]))
        else $error("Disabled slot reported a match");

    // Match pulse sets its flag
    chk_hit_sets_flag: assert property (
        wake_hit_o[0] |=> evt_status_q[0])
        else $error("Match flag not set");

    // An enabled slot 1 flag drives the interrupt
    chk_irq_follows_flag: assert property (
        evt_status_q[1] && evt_enable_q[1] |-> irq_o)
        else $error("Interrupt missing for enabled flag");

    // First byte of a frame
    chk_byte1_select: assert property (
        rx_valid_i && byte_cnt_q == 7'h00 |-> byte_sel[0] == p0_mask_q[0][0])
        else $error("Byte 1 misplaced");

    // Byte 33 opens word 2
    chk_byte33_select: assert property (
        rx_valid_i && byte_cnt_q == 7'h20 |-> byte_sel[0] == p0_mask_q[2][0])
        else $error("Byte 33 misplaced");

    // Byte 64 closes word 3
    chk_byte64_select: assert property (
        rx_valid_i && byte_cnt_q == 7'h3f |-> byte_sel[1] == p1_mask_q[3][15])
        else $error("Byte 64 misplaced");

    // A match outlives a clear
    chk_set_beats_clear: assert property (
        hit != 3'h0 |=> (evt_status_q & $past(hit)) == $past(hit))
        else $error("Match flag lost");

    // A clear with no match empties the bits
    chk_clear_drops_flag: assert property (
        wr_take && sel_i[0] && idx == wake_regs_pkg::IDX_EVT_CLEAR && hit == 3'h0
        |=> (evt_status_q & $past(dat_i[2:0])) == 3'h0)
        else $error("Flag survived a clear");

    // Counter restarts after the last byte
    chk_count_restart: assert property (
        frame_end |=> byte_cnt_q == wake_regs_pkg::COUNT_RESET)
        else $error("Count not restarted");

    // Long frames park the counter at 64
    chk_count_parks: assert property (
        rx_valid_i && !rx_last_i && byte_cnt_q == 7'h40 |=> byte_cnt_q == 7'h40)
        else $error("Count left 64");
endmodule // wake_frame_mask_crc_regs
`default_nettype wire

/* rtl/wake_pattern_matcher.sv */
`timescale 1ns/100ps
`default_nettype none
// One pattern slot: masked CRC accumulation and end-of-frame compare
module wake_pattern_matcher (
    input  wire logic        clk_i,           // Core clock
    input  wire logic        rst_i,           // Synchronous reset, high
    input  wire logic        enable_i,        // Slot detect enable
    input  wire logic        byte_valid_i,    // Received byte strobe
    input  wire logic [7:0]  byte_data_i,     // Received byte
    input  wire logic        byte_select_i,   // Byte chosen by mask
    input  wire logic        frame_end_i,     // Byte is last of frame
    input  wire logic [31:0] expected_crc_i,  // Software expected CRC
    output logic             hit_o            // One-cycle match pulse
);
    logic [31:0] crc_q;   // Running CRC
    logic [31:0] crc_d;   // CRC after this byte
    logic        hit_q;   // Registered match

    // Bitwise serial CRC over one byte, LSB first
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r >> 1) ^ (wake_regs_pkg::CRC_POLY & {32{r[0] ^ d[i]}});
        end
        return r;
    endfunction

    // Only masked bytes advance the CRC
    always_comb begin
        crc_d = byte_select_i ? crc_byte(crc_q, byte_data_i) : crc_q;
    end

    // Accumulator restarts every frame and while disabled
    always_ff @(posedge clk_i) begin
        if (rst_i || !enable_i) begin
            crc_q <= wake_regs_pkg::CRC_INIT;
        end else if (byte_valid_i) begin
            crc_q <= frame_end_i ? wake_regs_pkg::CRC_INIT : crc_d;
        end
    end

    // Compare at frame end against this slot's own value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hit_q <= 1'b0;
        end else begin
            hit_q <= enable_i && byte_valid_i && frame_end_i
                     && ((crc_d ^ wake_regs_pkg::CRC_FINAL_XOR) == expected_crc_i);
        end
    end

    assign hit_o = hit_q;

    // Unselected byte leaves the CRC alone
    chk_crc_hold_unselected: assert property (@(posedge clk_i) disable iff (rst_i)
        (enable_i && byte_valid_i && !byte_select_i && !frame_end_i) ##1 enable_i
        |-> crc_q == $past(crc_q))
        else $error("CRC moved on an unselected byte");

    // A hit only follows an enabled frame end
    chk_hit_after_end: assert property (@(posedge clk_i) disable iff (rst_i)
        hit_o |-> $past(frame_end_i && byte_valid_i && enable_i))
        else $error("Hit without an enabled frame end");
endmodule // wake_pattern_matcher
`default_nettype wire

/* rtl/wake_regs_pkg.sv */
package wake_regs_pkg;
    // Register indices; byte address is four times the index
    localparam logic [9:0]  IDX_P0_MASK0    = 10'h134;
    localparam logic [9:0]  IDX_P0_MASK1    = 10'h136;
    localparam logic [9:0]  IDX_P0_MASK2    = 10'h138;
    localparam logic [9:0]  IDX_P0_MASK3    = 10'h13a;
    localparam logic [9:0]  IDX_DETECT_EN   = 10'h13c;
    localparam logic [9:0]  IDX_P1_CRC_LO   = 10'h140;
    localparam logic [9:0]  IDX_P1_CRC_HI   = 10'h142;
    localparam logic [9:0]  IDX_P1_MASK0    = 10'h144;
    localparam logic [9:0]  IDX_P1_MASK1    = 10'h146;
    localparam logic [9:0]  IDX_P1_MASK2    = 10'h148;
    localparam logic [9:0]  IDX_P1_MASK3    = 10'h14a;
    localparam logic [9:0]  IDX_EVT_STATUS  = 10'h14c;
    localparam logic [9:0]  IDX_EVT_CLEAR   = 10'h14e;
    localparam logic [9:0]  IDX_P2_CRC_LO   = 10'h150;
    localparam logic [9:0]  IDX_P2_CRC_HI   = 10'h152;
    localparam logic [9:0]  IDX_EVT_ENABLE  = 10'h15c;
    // Field layout and reset values
    localparam int          NUM_PATTERNS    = 3;
    localparam logic [15:0] RESET_WORD      = 16'h0000;
    localparam logic [2:0]  RESET_FLAGS     = 3'h0;
    localparam logic [6:0]  WINDOW_BYTES    = 7'h40;
    localparam logic [6:0]  COUNT_RESET     = 7'h00;
    // Ethernet CRC, bit-reflected form
    localparam logic [31:0] CRC_INIT        = 32'hffffffff;
    localparam logic [31:0] CRC_POLY        = 32'hedb88320;
    localparam logic [31:0] CRC_FINAL_XOR   = 32'hffffffff;
endpackage

/* tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        clk_i  = 1'b0;          // Core clock
    logic        rst_i  = 1'b1;          // Reset, held at start
    logic [11:0] adr_i  = 12'h000;       // Bus address
    logic [31:0] dat_i  = 32'h0;         // Bus write data
    logic [3:0]  sel_i  = 4'h0;          // Bus lane selects
    logic        we_i   = 1'b0;          // Bus write
    logic        cyc_i  = 1'b0;          // Bus cycle
    logic        stb_i  = 1'b0;          // Bus strobe
    logic [31:0] dat_o;                  // Read data
    logic        ack_o;                  // Acknowledge
    logic        rx_valid;               // Byte strobe from model
    logic [7:0]  rx_data;                // Byte from model
    logic        rx_last;                // Last byte from model
    logic [31:0] crc0_q = 32'h0;         // Slot 0 expected CRC
    logic [63:0] mask2_q = 64'h0;        // Slot 2 masks
    logic [2:0]  wake_hit_o;             // Match pulses
    logic        irq_o;                  // Interrupt
    logic [2:0]  hit_seen_q = 3'h0;      // Pulses gathered per frame
    logic        hit_clr = 1'b0;         // Clears the gathered pulses
    int          fail_count = 0;         // Mismatches
    int          compares = 0;           // Comparisons
    logic [31:0] rd;                     // Last read value
    localparam logic [9:0] RW_REGS [12] = '{
        wake_regs_pkg::IDX_P0_MASK0, wake_regs_pkg::IDX_P0_MASK1, wake_regs_pkg::IDX_P0_MASK2,
        wake_regs_pkg::IDX_P0_MASK3, wake_regs_pkg::IDX_P1_CRC_LO, wake_regs_pkg::IDX_P1_CRC_HI,
        wake_regs_pkg::IDX_P1_MASK0, wake_regs_pkg::IDX_P1_MASK1, wake_regs_pkg::IDX_P1_MASK2,
        wake_regs_pkg::IDX_P1_MASK3, wake_regs_pkg::IDX_P2_CRC_LO, wake_regs_pkg::IDX_P2_CRC_HI};
    localparam logic [63:0] M0 = 64'h8001_8001_8001_8001; // Edge bytes of every word
    localparam logic [63:0] M1 = 64'h00ff_0f00_f000_000f; // Scattered bytes
    localparam logic [63:0] M2 = 64'h8000_0000_0000_0001; // Byte 1 and byte 64

    always #10 clk_i = ~clk_i;

    wake_frame_mask_crc_regs i_wake_frame_mask_crc_regs (
        .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
        .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
        .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_last_i(rx_last),
        .pattern0_expected_crc_i(crc0_q), .pattern2_mask_i(mask2_q),
        .wake_hit_o(wake_hit_o), .irq_o(irq_o));
    wake_frame_source i_wake_frame_source (
        .clk_i(clk_i), .rx_valid_o(rx_valid), .rx_data_o(rx_data), .rx_last_o(rx_last));

    // Gathers match pulses so the frame task can judge them afterwards
    always @(posedge clk_i) begin
        hit_seen_q <= hit_clr ? 3'h0 : (hit_seen_q | wake_hit_o);
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (fail_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One classic cycle; waits for ack, checks latency
    task automatic wb(input logic w, input logic [9:0] idx, input logic [15:0] wd,
                      input logic [3:0] sl);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= {idx, 2'b00};
        dat_i <= {16'h0, wd};
        sel_i <= sl;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1);
        chk("ack latency", 32'(n), 32'h2);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    endtask
    task automatic rchk(input string name, input logic [9:0] idx, input logic [31:0] exp);
        wb(1'b0, idx, 16'h0, 4'h3);
        chk(name, rd, exp);
    endtask
    // Reference CRC over the masked bytes of the model's frame
    function automatic logic [31:0] ref_crc(input logic [63:0] m);
        logic [31:0] c;
        logic [7:0]  d;
        c = wake_regs_pkg::CRC_INIT;
        for (int n = 1; n <= 64; n++) begin
            d = 8'((n * 37) + 5);
            if (m[n-1]) begin
                for (int b = 0; b < 8; b++) begin
                    c = (c[0] ^ d[b]) ? ((c >> 1) ^ wake_regs_pkg::CRC_POLY) : (c >> 1);
                end
            end
        end
        return c ^ wake_regs_pkg::CRC_FINAL_XOR;
    endfunction
    task automatic set_masks(input logic [9:0] idx0, input logic [63:0] m);
        for (int i = 0; i < 4; i++) wb(1'b1, idx0 + 10'(2 * i), m[16*i +: 16], 4'h3);
    endtask
    task automatic set_crc(input logic [9:0] lo, input logic [31:0] v);
        wb(1'b1, lo, v[15:0], 4'h3);                 // Low half
        wb(1'b1, lo + 10'h2, v[31:16], 4'h3);        // High half
    endtask
    task automatic frame(input int len, input int gap, input logic [2:0] exp);
        @(posedge clk_i);
        hit_clr <= 1'b1;
        @(posedge clk_i);
        hit_clr <= 1'b0;
        i_wake_frame_source.send(len, gap);
        repeat (3) @(posedge clk_i);
        chk("hits", {29'h0, hit_seen_q}, {29'h0, exp});
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Watchdog: whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        stop_test();
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset values, then write and read back every mask and CRC register
        foreach (RW_REGS[i]) rchk("reset", RW_REGS[i], 32'h0);
        foreach (RW_REGS[i]) wb(1'b1, RW_REGS[i], {RW_REGS[i][7:0], 8'(i) ^ 8'hc3}, 4'h3);
        foreach (RW_REGS[i]) rchk("rw", RW_REGS[i], {16'h0, RW_REGS[i][7:0], 8'(i) ^ 8'hc3});
        // One lane only: low byte must survive
        wb(1'b1, wake_regs_pkg::IDX_P1_MASK0, 16'habcd, 4'h2);
        rchk("lane", wake_regs_pkg::IDX_P1_MASK0, 32'h0000_abc5);
        rchk("unmapped", 10'h100, 32'h0);
        wb(1'b1, wake_regs_pkg::IDX_EVT_STATUS, 16'h7, 4'h3);
        rchk("status ro", wake_regs_pkg::IDX_EVT_STATUS, 32'h0);
        // Three slots, slot 2 given a wrong CRC; bytes past 64 sent too
        set_masks(wake_regs_pkg::IDX_P0_MASK0, M0);
        set_masks(wake_regs_pkg::IDX_P1_MASK0, M1);
        set_crc(wake_regs_pkg::IDX_P1_CRC_LO, ref_crc(M1));
        set_crc(wake_regs_pkg::IDX_P2_CRC_LO, ref_crc(M2) ^ 32'h1);
        crc0_q  <= ref_crc(M0);
        mask2_q <= M2;
        wb(1'b1, wake_regs_pkg::IDX_DETECT_EN, 16'h7, 4'h3);
        wb(1'b1, wake_regs_pkg::IDX_EVT_ENABLE, 16'h1, 4'h3);
        frame(70, 0, 3'b011);
        rchk("status", wake_regs_pkg::IDX_EVT_STATUS, 32'h3);
        chk("irq set", {31'h0, irq_o}, 32'h1);
        wb(1'b1, wake_regs_pkg::IDX_EVT_CLEAR, 16'h1, 4'h3);
        rchk("status clr", wake_regs_pkg::IDX_EVT_STATUS, 32'h2);
        chk("irq masked", {31'h0, irq_o}, 32'h0);
        wb(1'b1, wake_regs_pkg::IDX_EVT_ENABLE, 16'h2, 4'h3);
        @(posedge clk_i);
        chk("irq enabled", {31'h0, irq_o}, 32'h1);
        wb(1'b1, wake_regs_pkg::IDX_EVT_CLEAR, 16'h7, 4'h3);
        @(posedge clk_i);
        chk("irq cleared", {31'h0, irq_o}, 32'h0);
        // Slot 0 disabled, slot 1 zero mask, slow byte spacing
        set_crc(wake_regs_pkg::IDX_P2_CRC_LO, ref_crc(M2));
        set_masks(wake_regs_pkg::IDX_P1_MASK0, 64'h0);
        set_crc(wake_regs_pkg::IDX_P1_CRC_LO, 32'h0);
        wb(1'b1, wake_regs_pkg::IDX_DETECT_EN, 16'h6, 4'h3);
        frame(64, 2, 3'b110);
        rchk("status b", wake_regs_pkg::IDX_EVT_STATUS, 32'h6);
        stop_test();
    end
endmodule // tb
`default_nettype wire

/* tb/wake_frame_source.sv */
`timescale 1ns/100ps
`default_nettype none
// Received byte stream model standing in for the switch port
module wake_frame_source (
    input  wire logic       clk_i,       // Core clock
    output logic            rx_valid_o,  // Byte strobe
    output logic [7:0]      rx_data_o,   // Byte value
    output logic            rx_last_o    // Last byte of frame
);
    initial begin
        rx_valid_o = 1'b0;
        rx_data_o  = 8'h5a;
        rx_last_o  = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // Byte n of every frame, counted from 1
    function automatic logic [7:0] byte_at(input int n);
        return 8'((n * 37) + 5);
    endfunction
    // Sends len bytes, gap idle cycles after each one
    task automatic send(input int len, input int gap);
        for (int k = 1; k <= len; k++) begin
            @(posedge clk_i);
            rx_valid_o <= 1'b1;
            rx_data_o  <= byte_at(k);     // First byte is byte 1
            rx_last_o  <= (k == len);
            // Idle data flips so a stale byte is never mistaken for valid
            repeat (gap) begin
                @(posedge clk_i);
                rx_valid_o <= 1'b0;
                rx_last_o  <= 1'b0;
                rx_data_o  <= ~rx_data_o;
            end
        end
        @(posedge clk_i);
        rx_valid_o <= 1'b0;
        rx_last_o  <= 1'b0;
        rx_data_o  <= ~rx_data_o;
    endtask
endmodule // wake_frame_source
`default_nettype wire
